// [hw/fgl_linearizer_top.sv]
/*
  Field sample conditioning: gain with temperature drift, offset with
  drift, then a 17-point piecewise-linear map with a binning mode.
  Assumes samples and temperature come from logic on clk_sys.
*/
// What this block does
// [R1] Gain = polarity, coarse, fine and one plus warm/cool drift term.
// [R2] Gain stage result is a signed 17-bit integer.
// [R3] Delta temperature is ambient minus 25; its sign picks warm or cool.
// [R4] Offset adds fixed offset plus drift times delta; signed 13-bit result.
// [R5] Offset drift is first order only, per region, same boundary.
// [R6] Polarity bit 15 of word 0x3; set inverts gain sign.
// [R7] Coarse gain bits 14:12, fine gain bits 10:0 of trim word.
// [R8] Word 0x4: first order warm bits 10:0, cool bits 22:12.
// [R9] Word 0x5: second order warm bits 9:0, cool bits 21:12.
// [R10] Word 0x6 bits 15:0 fixed offset; word 0x7 drift 11:0, 23:12.
// [R11] Map of 17 programmable 12-bit breakpoints, fixed equal output steps.
// [R12] Software keeps breakpoints non-decreasing; equal ones skip levels.
// [R13] Below first breakpoint extrapolate -2048/-1792 line, floor -2304.
// [R14] Above last breakpoint extrapolate 1792/2048 line, ceiling 2304.
// [R15] Between breakpoints interpolate linearly, signed 13-bit output.
// [R16] Bit 13 of word 0x12 selects binning: level of greatest bp <= input.
// [R17] Binning gives -3072 below lowest and 2048 above highest breakpoint.
// [R18] Map applies only when bit 12 of word 0x12 is one.
// [R19] Bit 14 inverts map output, bit 15 inverts map input.
// [R20] Even breakpoints in table words 0..8, odd in words 0..7.
// [R21] Fine gain applies after coarse gain.
// [R22] Temperature is a signed input; one registered result per sample.
// [R23] Oversized stage results saturate instead of wrapping.
`timescale 1ns/10ps
module fgl_linearizer_top
  import fgl_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  // Register port
  input  wire fgl_req_t                     regReq,
  output logic             [DATA_W-1:0]     regRdata,
  // Sample input
  input  wire logic                         sampleValid,
  input  wire logic signed [SAMPLE_W-1:0]   sampleData,
  input  wire logic signed [TEMP_W-1:0]     tempC,
  // Conditioned output
  output fgl_out_t                          outSample
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic signed [63:0] satW(
    input logic signed [63:0] v,
    input int                 w
  );
    logic signed [63:0] hi;
    logic signed [63:0] lo;
    hi = (64'sh1 <<< (w - 1)) - 64'sh1;
    lo = -hi - 64'sh1;
    if (v > hi) begin
      satW = hi;
    end else if (v < lo) begin
      satW = lo;
    end else begin
      satW = v;
    end
  endfunction : satW

  function automatic logic signed [63:0] levelOf(input int k);
    levelOf = 64'(LVL_FIRST + LVL_STEP * k);
  endfunction : levelOf

  function automatic logic signed [63:0] lerp(
    input logic signed [63:0] base,
    input logic signed [63:0] num,
    input logic signed [63:0] den
  );
    lerp = base + (num * 64'(LVL_STEP)) / den;
  endfunction : lerp

  // ****************************************
  // Register file
  // ****************************************
  logic [DATA_W-1:0] gainTrim_reg;
  logic [DATA_W-1:0] gainDrf1_reg;
  logic [DATA_W-1:0] gainDrf2_reg;
  logic [DATA_W-1:0] qOffset_reg;
  logic [DATA_W-1:0] ofsDrift_reg;
  logic [DATA_W-1:0] table_reg [0:N_TABLE-1];
  logic [DATA_W-1:0] regRdata_next;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gainTrim_reg <= RST_GAIN_TRIM;
      gainDrf1_reg <= RST_ZERO;
      gainDrf2_reg <= RST_ZERO;
      qOffset_reg  <= RST_ZERO;
      ofsDrift_reg <= RST_ZERO;
    end else if (regReq.wr) begin
      case (regReq.addr)
        ADR_GAIN_TRIM: gainTrim_reg <= regReq.wdata;
        ADR_GAIN_DRF1: gainDrf1_reg <= regReq.wdata;
        ADR_GAIN_DRF2: gainDrf2_reg <= regReq.wdata;
        ADR_QOFFSET:   qOffset_reg  <= regReq.wdata;
        ADR_OFS_DRIFT: ofsDrift_reg <= regReq.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < N_TABLE; i++) begin
      if (srst) begin
        table_reg[i] <= RST_ZERO;
      end else if (regReq.wr && regReq.addr == ADR_TABLE0 + 5'(i)) begin
        table_reg[i] <= regReq.wdata;
      end
    end
  end

  // Field decode
  logic                 polInv;
  logic [2:0]           coarseCode;
  logic [FINE_MSB:0]    fineCode;
  logic                 linEn;
  logic                 binMode;
  logic                 outInv;
  logic                 inInv;
  logic signed [BP_W-1:0] bp [0:N_POINTS-1];

  assign polInv     = gainTrim_reg[POL_BIT];                   // R6
  assign coarseCode = gainTrim_reg[COARSE_MSB:COARSE_LSB];     // R7
  assign fineCode   = gainTrim_reg[FINE_MSB:0];                // R7
  assign linEn      = table_reg[N_TABLE-1][LIN_EN_BIT];
  assign binMode    = table_reg[N_TABLE-1][BIN_BIT];
  assign outInv     = table_reg[N_TABLE-1][OINV_BIT];
  assign inInv      = table_reg[N_TABLE-1][IINV_BIT];

  always_comb begin
    for (int i = 0; i < N_TABLE - 1; i++) begin
      bp[2*i]   = $signed(table_reg[i][BP_W-1:0]);              // R20
      bp[2*i+1] = $signed(table_reg[i][HI_LSB+BP_W-1:HI_LSB]);  // R20
    end
    bp[N_POINTS-1] = $signed(table_reg[N_TABLE-1][BP_W-1:0]);  // R20
  end

  // ****************************************
  // Stage 1: capture sample and delta
  // ****************************************
  logic                        v1_reg;
  logic signed [SAMPLE_W-1:0]  x1_reg;
  logic signed [DT_W-1:0]      dT1_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      v1_reg <= 1'b0;
    end else begin
      v1_reg <= sampleValid;                                     // R22
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sampleValid) begin
      x1_reg  <= sampleData;
      dT1_reg <= DT_W'(tempC) - DT_W'(TEMP_REF);                 // R3
    end
  end

  // ****************************************
  // Stage 2: static gain and drift factor
  // ****************************************
  logic                       v2_reg;
  logic signed [63:0]         g2_reg;
  logic signed [63:0]         corr2_reg;
  logic signed [DT_W-1:0]     dT2_reg;
  logic signed [63:0]         g2_next;
  logic signed [63:0]         corr2_next;

  always_comb begin
    logic signed [63:0] coarse;
    logic signed [63:0] dt;
    logic signed [63:0] tc1;
    logic signed [63:0] tc2;
    logic               cool;
    tc1 = '0;
    tc2 = '0;
    coarse = x1_reg * (64'sh1 <<< coarseCode);
    g2_next = (coarse * (64'(FINE_BASE) + $signed(64'(fineCode))))
              >>> FINE_SHIFT;                                    // R21
    if (polInv) begin
      g2_next = -g2_next;                                        // R6
    end
    dt   = 64'(dT1_reg);
    cool = dT1_reg < 0;                                          // R3
    if (cool) begin                                              // R1
      tc1 = 64'($signed(gainDrf1_reg[TC1_C_MSB:HI_LSB]));        // R8
      tc2 = 64'($signed(gainDrf2_reg[TC2_C_MSB:HI_LSB]));        // R9
      corr2_next = ((tc1 * dt) <<< TC1_C_SH)
                 + ((tc2 * dt * dt) <<< TC2_C_SH);
    end else begin
      tc1 = 64'($signed(gainDrf1_reg[TC1_W_MSB:0]));             // R8
      tc2 = 64'($signed(gainDrf2_reg[TC2_W_MSB:0]));             // R9
      corr2_next = ((tc1 * dt) <<< TC1_W_SH)
                 + ((tc2 * dt * dt) <<< TC2_W_SH);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      v2_reg <= 1'b0;
    end else begin
      v2_reg <= v1_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    g2_reg    <= g2_next;
    corr2_reg <= corr2_next;
    dT2_reg   <= dT1_reg;
  end

  // ****************************************
  // Stage 3: apply drift factor
  // ****************************************
  logic                       v3_reg;
  logic signed [Y1_W-1:0]     y1_reg;
  logic signed [DT_W-1:0]     dT3_reg;
  logic signed [63:0]         y1Wide;

  assign y1Wide = g2_reg + ((g2_reg * corr2_reg) >>> CORR_FRAC); // R1

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      v3_reg <= 1'b0;
    end else begin
      v3_reg <= v2_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    y1_reg  <= Y1_W'(satW(y1Wide, Y1_W));                        // R2 R23
    dT3_reg <= dT2_reg;
  end

  // ****************************************
  // Stage 4: offset and offset drift
  // ****************************************
  logic                       v4_reg;
  logic signed [Y2_W-1:0]     y2_reg;
  logic signed [63:0]         y2Wide;

  always_comb begin
    logic signed [63:0] qotc;
    logic signed [63:0] dt;
    qotc = '0;
    dt = 64'(dT3_reg);
    if (dT3_reg < 0) begin                                       // R5
      qotc = 64'($signed(ofsDrift_reg[QOTC_C_MSB:HI_LSB]));      // R10
      qotc = (qotc * dt) >>> QOTC_C_SH;
    end else begin
      qotc = 64'($signed(ofsDrift_reg[QOTC_W_MSB:0]));           // R10
      qotc = (qotc * dt) >>> QOTC_W_SH;
    end
    y2Wide = 64'(y1_reg) + 64'($signed(qOffset_reg[QO_MSB:0]))
           + qotc;                                               // R4 R10
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      v4_reg <= 1'b0;
    end else begin
      v4_reg <= v3_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    y2_reg <= Y2_W'(satW(y2Wide, Y2_W));                         // R4 R23
  end

  // ****************************************
  // Stage 5: piecewise-linear map
  // ****************************************
  logic signed [63:0] linIn;
  logic signed [63:0] linY;
  logic signed [Y2_W-1:0] out_next;
  logic                   belowAll;
  logic                   aboveAll;
  int                     segIdx;

  always_comb begin
    logic signed [63:0] x;
    logic signed [63:0] den;
    int                 nxt;
    den = '0;
    nxt = 0;
    x = 64'(y2_reg);
    if (inInv) begin
      x = satW(-x, Y2_W);                                        // R19
    end
    linIn = x;
    // Greatest index with breakpoint <= input, given ordered table
    segIdx = 0;
    for (int i = 0; i < N_POINTS; i++) begin
      if (x >= 64'(bp[i])) begin
        segIdx = i;                                              // R11 R12
      end
    end
    nxt      = (segIdx == N_POINTS - 1) ? segIdx : segIdx + 1;
    belowAll = x < 64'(bp[0]);
    aboveAll = x > 64'(bp[N_POINTS-1]);
    if (binMode) begin                                           // R16
      linY = belowAll ? 64'(BIN_BELOW) : levelOf(segIdx);        // R17
    end else if (belowAll) begin
      den = 64'(bp[1]) - 64'(bp[0]);
      linY = (den == 0) ? 64'(EXTRAP_MIN)
           : lerp(64'(LVL_FIRST), x - 64'(bp[0]), den);          // R13
      if (linY < 64'(EXTRAP_MIN)) begin
        linY = 64'(EXTRAP_MIN);                                  // R13
      end
    end else if (aboveAll) begin
      den = 64'(bp[N_POINTS-1]) - 64'(bp[N_POINTS-2]);
      linY = (den == 0) ? 64'(EXTRAP_MAX)
           : lerp(64'(LVL_PENULT), x - 64'(bp[N_POINTS-2]), den); // R14
      if (linY > 64'(EXTRAP_MAX)) begin
        linY = 64'(EXTRAP_MAX);                                  // R14
      end
    end else if (segIdx == N_POINTS - 1) begin
      linY = 64'(LVL_LAST);
    end else begin
      den  = 64'(bp[nxt]) - 64'(bp[segIdx]);
      linY = lerp(levelOf(segIdx), x - 64'(bp[segIdx]), den);    // R15
    end
    if (outInv) begin
      linY = -linY;                                              // R19
    end
    out_next = linEn ? Y2_W'(satW(linY, Y2_W)) : y2_reg;         // R18 R15
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      outSample <= '0;
    end else begin
      outSample.valid <= v4_reg;                                 // R22
      if (v4_reg) begin
        outSample.data <= out_next;
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_comb begin
    regRdata_next = '0;
    case (regReq.addr)
      ADR_GAIN_TRIM: regRdata_next = gainTrim_reg;
      ADR_GAIN_DRF1: regRdata_next = gainDrf1_reg;
      ADR_GAIN_DRF2: regRdata_next = gainDrf2_reg;
      ADR_QOFFSET:   regRdata_next = qOffset_reg;
      ADR_OFS_DRIFT: regRdata_next = ofsDrift_reg;
      ADR_LAST_OUT:  regRdata_next = {{(DATA_W-Y2_W){1'b0}},
                                      outSample.data};
      default: begin
        if (regReq.addr >= ADR_TABLE0 && regReq.addr <= ADR_TABLE_LAST)
        begin
          regRdata_next = table_reg[4'(regReq.addr - ADR_TABLE0)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regReq.rd ? regRdata_next : '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  latency_a: assert property ( // R22
    sampleValid |-> ##5 outSample.valid)
    else $error("result not delivered five cycles after sample");

  delta_temp_a: assert property ( // R3
    sampleValid |=> dT1_reg == DT_W'($past(tempC)) - DT_W'(TEMP_REF))
    else $error("temperature delta wrong");

  map_bypass_a: assert property ( // R18
    v4_reg && !linEn |=> outSample.data == $past(y2_reg))
    else $error("disabled map changed value");

  bin_low_a: assert property ( // R17
    v4_reg && linEn && binMode && !outInv && belowAll
    |=> outSample.data == Y2_W'(BIN_BELOW))
    else $error("binning below lowest point wrong");

  bin_high_a: assert property ( // R17
    v4_reg && linEn && binMode && !outInv && aboveAll
    |=> outSample.data == Y2_W'(LVL_LAST))
    else $error("binning above highest point wrong");

  extrap_floor_a: assert property ( // R13
    v4_reg && linEn && !binMode && !outInv && belowAll
    |=> outSample.data >= Y2_W'(EXTRAP_MIN)
        && outSample.data <= Y2_W'(LVL_FIRST))
    else $error("low extrapolation out of range");

  extrap_ceil_a: assert property ( // R14
    v4_reg && linEn && !binMode && !outInv && aboveAll
    |=> outSample.data <= Y2_W'(EXTRAP_MAX)
        && outSample.data >= Y2_W'(LVL_LAST))
    else $error("high extrapolation out of range");

  point_hit_a: assert property ( // R15
    v4_reg && linEn && !binMode && !outInv && !belowAll
    && linIn == 64'(bp[segIdx]) && segIdx > 0
    && 64'(bp[segIdx-1]) != linIn
    |=> outSample.data == Y2_W'(levelOf($past(segIdx))))
    else $error("breakpoint does not yield its level");

  gain_sat_a: assert property ( // R23
    v2_reg && y1Wide > 64'((1 <<< (Y1_W - 1)) - 1)
    |=> y1_reg == Y1_W'((1 <<< (Y1_W - 1)) - 1))
    else $error("gain stage did not saturate high");

  read_back_a: assert property ( // R6
    regReq.wr && regReq.addr == ADR_GAIN_TRIM ##1
    regReq.rd && regReq.addr == ADR_GAIN_TRIM
    |=> regRdata == $past(regReq.wdata, 2))
    else $error("trim word read back wrong");

  bin_cov: cover property (v4_reg && linEn && binMode);
  interp_cov: cover property (v4_reg && linEn && !binMode && !belowAll
                              && !aboveAll);
  extrap_cov: cover property (v4_reg && linEn && !binMode && belowAll);
  cool_cov: cover property (sampleValid && tempC < TEMP_W'(TEMP_REF));

endmodule : fgl_linearizer_top

// [include/fgl_pkg.sv]
/*
  Constants, register map and carrier types of the field gain, offset and
  linearizer datapath.
  Assumes one system clock and a word-addressed register port.
*/
package fgl_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 24;
  localparam int SAMPLE_W = 16;
  localparam int TEMP_W   = 8;
  localparam int DT_W     = 9;
  localparam int Y1_W     = 17;
  localparam int Y2_W     = 13;
  localparam int BP_W     = 12;
  localparam int N_POINTS = 17;
  localparam int N_TABLE  = 9;

  // ****************************************
  // Register word addresses
  // ****************************************
  localparam logic [4:0] ADR_GAIN_TRIM  = 5'h03;
  localparam logic [4:0] ADR_GAIN_DRF1  = 5'h04;
  localparam logic [4:0] ADR_GAIN_DRF2  = 5'h05;
  localparam logic [4:0] ADR_QOFFSET    = 5'h06;
  localparam logic [4:0] ADR_OFS_DRIFT  = 5'h07;
  localparam logic [4:0] ADR_TABLE0     = 5'h0A;
  localparam logic [4:0] ADR_TABLE_LAST = 5'h12;
  localparam logic [4:0] ADR_LAST_OUT   = 5'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POL_BIT    = 15;
  localparam int COARSE_MSB = 14;
  localparam int COARSE_LSB = 12;
  localparam int FINE_MSB   = 10;
  localparam int TC1_W_MSB  = 10;
  localparam int TC1_C_MSB  = 22;
  localparam int TC2_W_MSB  = 9;
  localparam int TC2_C_MSB  = 21;
  localparam int QO_MSB     = 15;
  localparam int QOTC_W_MSB = 11;
  localparam int QOTC_C_MSB = 23;
  localparam int HI_LSB     = 12;
  localparam int LIN_EN_BIT = 12;
  localparam int BIN_BIT    = 13;
  localparam int OINV_BIT   = 14;
  localparam int IINV_BIT   = 15;

  // ****************************************
  // Reset values and arithmetic scaling
  // ****************************************
  localparam logic [23:0] RST_GAIN_TRIM = 24'h000400;
  localparam logic [23:0] RST_ZERO      = 24'h000000;
  localparam int TEMP_REF    = 25;
  localparam int FINE_BASE   = 1024;
  localparam int FINE_SHIFT  = 11;
  localparam int CORR_FRAC   = 25;
  localparam int TC1_W_SH    = 7;
  localparam int TC1_C_SH    = 8;
  localparam int TC2_W_SH    = 0;
  localparam int TC2_C_SH    = 2;
  localparam int QOTC_W_SH   = 6;
  localparam int QOTC_C_SH   = 5;

  // ****************************************
  // Linearizer levels
  // ****************************************
  localparam int LVL_FIRST  = -2048;
  localparam int LVL_STEP   = 256;
  localparam int LVL_SEC    = -1792;
  localparam int LVL_PENULT = 1792;
  localparam int LVL_LAST   = 2048;
  localparam int EXTRAP_MIN = -2304;
  localparam int EXTRAP_MAX = 2304;
  localparam int BIN_BELOW  = -3072;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fgl_req_t;

  typedef struct packed {
    logic                   valid;
    logic signed [Y2_W-1:0] data;
  } fgl_out_t;

endpackage : fgl_pkg

// [verification/fgl_linearizer_top_tb.sv]
/*
  Self-checking bench of the conditioning datapath.
  Assumes the partner model feeds samples and collects results.
*/
`timescale 1ns/10ps
module fgl_linearizer_top_tb
  import fgl_pkg::*;
;
  logic                   clk_sys = 1'b0;
  logic                   srst = 1'b1;
  fgl_req_t               regReq = '0;
  logic [DATA_W-1:0]      regRdata;
  logic                   sampleValid;
  logic signed [15:0]     sampleData;
  logic signed [7:0]      tempC;
  fgl_out_t               outSample;
  logic signed [Y2_W-1:0] expQ[$];
  logic signed [Y2_W-1:0] lastOut;
  int                     mismatches = 0;
  int                     checks_done = 0;
  int                     cyc = 0;

  fgl_linearizer_top dut (.clk_sys(clk_sys), .srst(srst), .regReq(regReq),
    .regRdata(regRdata), .sampleValid(sampleValid),
    .sampleData(sampleData), .tempC(tempC), .outSample(outSample));
  fgl_stream_partner partner (.clk_sys(clk_sys), .srst(srst),
    .sampleValid(sampleValid), .sampleData(sampleData), .tempC(tempC),
    .outSample(outSample));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  // ****************************************
  // Compare, bus and stream tasks
  // ****************************************
  task automatic chk_reg(input logic [23:0] got, input logic [23:0] e);
    checks_done++;
    if (got !== e) begin
      mismatches++;
      $display("[FAIL] %0t reg %h exp %h", $time, got, e);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [12:0] got, input logic [12:0] e);
    checks_done++;
    if (got !== e) begin
      mismatches++;
      $display("[FAIL] %0t out %0d exp %0d", $time, $signed(got), $signed(e));
    end
  endtask : chk_out

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge clk_sys) regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) regReq <= '0;
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [23:0] e);
    @(posedge clk_sys) regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clk_sys) regReq <= '0;
    #1;
    chk_reg(regRdata, e);
  endtask : rd_chk

  task automatic samp(input logic signed [15:0] d,
                      input logic signed [7:0] t,
                      input logic signed [12:0] e);
    partner.sendQ.push_back(d);
    partner.tempQ.push_back(t);
    expQ.push_back(e);
  endtask : samp

  // Results in order, each exactly five cycles after its sample
  task automatic drain();
    int n;
    n = expQ.size();
    for (int i = 0; i < 300 && partner.gotQ.size() < n; i++)
      @(posedge clk_sys);
    #1;
    chk_reg(24'(partner.gotQ.size()), 24'(n));
    chk_reg(24'(partner.lateCnt), 24'h000000);
    while (expQ.size() > 0 && partner.gotQ.size() > 0) begin
      lastOut = expQ.pop_front();
      chk_out(partner.gotQ.pop_front(), lastOut);
    end
    expQ.delete();
  endtask : drain

  function automatic logic [11:0] bp(input int k);
    return 12'(100 * k - 800);
  endfunction : bp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [4:0] adr[6] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h12};
    foreach (adr[i]) rd_chk(adr[i], i == 0 ? RST_GAIN_TRIM : RST_ZERO);
    foreach (adr[i]) wr(adr[i], 24'hA5C3E1 ^ 24'(i));
    foreach (adr[i]) rd_chk(adr[i], 24'hA5C3E1 ^ 24'(i));
    wr(5'h1F, 24'h123456);
    rd_chk(5'h1F, 24'h000000);
    @(posedge clk_sys) regReq <= '{wr: 1'b1, rd: 1'b0, addr: ADR_GAIN_TRIM,
                                   wdata: 24'h00BEEF};
    @(posedge clk_sys) regReq <= '{wr: 1'b0, rd: 1'b1, addr: ADR_GAIN_TRIM,
                                   wdata: '0};
    @(posedge clk_sys) regReq <= '0;
    #1;
    chk_reg(regRdata, 24'h00BEEF);
    foreach (adr[i]) wr(adr[i], i == 0 ? RST_GAIN_TRIM : RST_ZERO);
  endtask : t_regs

  task automatic t_gain();
    samp(100, 25, 100);
    samp(5000, 25, 4095);
    samp(-5000, 25, -4096);
    drain();
    wr(ADR_GAIN_TRIM, 24'h008400);
    samp(100, 25, -100);
    drain();
    wr(ADR_GAIN_TRIM, 24'h002000);
    samp(100, 25, 200);
    drain();
    wr(ADR_GAIN_TRIM, 24'h0007FF);
    samp(2048, 25, 3071);
    drain();
    wr(ADR_GAIN_TRIM, 24'h007400);
    samp(100, 25, 4095);
    samp(1000, 25, 4095);
    drain();
    wr(ADR_GAIN_TRIM, RST_GAIN_TRIM);
  endtask : t_gain

  task automatic t_drift();
    wr(ADR_GAIN_DRF1, 24'h100100);
    samp(1024, 89, 1088);
    samp(1024, -39, 896);
    samp(1024, 25, 1024);
    drain();
    wr(ADR_GAIN_DRF1, 24'h000000);
    wr(ADR_GAIN_DRF2, 24'h100100);
    samp(1024, 89, 1056);
    samp(1024, -39, 1152);
    drain();
    wr(ADR_GAIN_DRF2, 24'h000000);
  endtask : t_drift

  task automatic t_offset();
    wr(ADR_QOFFSET, 24'h000064);
    wr(ADR_OFS_DRIFT, 24'h040040);
    samp(0, 89, 164);
    samp(0, -39, -28);
    samp(0, 25, 100);
    drain();
    wr(ADR_QOFFSET, 24'h000000);
    wr(ADR_OFS_DRIFT, 24'h000000);
  endtask : t_offset

  task automatic t_map();
    for (int i = 0; i < 8; i++)
      wr(ADR_TABLE0 + 5'(i), {bp(2 * i + 1), bp(2 * i)});
    wr(ADR_TABLE_LAST, {8'h00, 4'h1, bp(16)});
    samp(-800, 25, -2048);
    samp(-750, 25, -1920);
    samp(0, 25, 0);
    samp(800, 25, 2048);
    samp(850, 25, 2176);
    samp(1000, 25, 2304);
    samp(-850, 25, -2176);
    samp(-1000, 25, -2304);
    drain();
    wr(ADR_TABLE_LAST, {8'h00, 4'h3, bp(16)});
    samp(-750, 25, -2048);
    samp(799, 25, 1792);
    samp(-801, 25, -3072);
    samp(850, 25, 2048);
    drain();
    wr(ADR_TABLE_LAST, {8'h00, 4'h5, bp(16)});
    samp(-725, 25, 1856);
    drain();
    wr(ADR_TABLE_LAST, {8'h00, 4'h9, bp(16)});
    samp(-725, 25, 1856);
    drain();
    wr(ADR_TABLE_LAST, {8'h00, 4'h0, bp(16)});
    samp(-725, 25, -725);
    drain();
    wr(ADR_LAST_OUT, 24'hFFFFFF);
    rd_chk(ADR_LAST_OUT, {11'h000, lastOut});
    rd_chk(ADR_TABLE_LAST, {12'h000, bp(16)});
  endtask : t_map

  task automatic finish_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_gain();
    t_drift();
    t_offset();
    t_map();
    finish_test();
  end
endmodule : fgl_linearizer_top_tb

// [verification/fgl_stream_partner.sv]
/*
  Upstream sample source and downstream result sink for the datapath.
  Assumes the bench fills sendQ/tempQ and empties gotQ.
*/
`timescale 1ns/10ps
module fgl_stream_partner
  import fgl_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  // Stream towards the block
  output logic                            sampleValid,
  output logic signed [SAMPLE_W-1:0]      sampleData,
  output logic signed [TEMP_W-1:0]        tempC,
  // Results from the block
  input  wire fgl_out_t                   outSample
);
  logic signed [SAMPLE_W-1:0] sendQ[$];
  logic signed [TEMP_W-1:0]   tempQ[$];
  logic signed [Y2_W-1:0]     gotQ[$];
  int                         sentAt[$];
  int                         cycle = 0;
  int                         lateCnt = 0;

  initial begin
    sampleValid = 1'b0;
    sampleData  = '0;
    tempC       = '0;
  end

  // ****************************************
  // One sample per cycle, idle lines toggle
  // ****************************************
  always @(posedge clk_sys) begin
    if (outSample.valid) begin
      gotQ.push_back(outSample.data);
      if (sentAt.size() == 0 || cycle - sentAt.pop_front() != 6)
        lateCnt++;
    end
    if (!srst && sendQ.size() > 0) begin
      sampleValid <= 1'b1;
      sampleData  <= sendQ.pop_front();
      tempC       <= tempQ.pop_front();
      sentAt.push_back(cycle);
    end else begin
      sampleValid <= 1'b0;
      sampleData  <= ~sampleData;
      tempC       <= ~tempC;
    end
    cycle++;
  end
endmodule : fgl_stream_partner
